/* File: swt_pkg.sv */
// Package for the stop-mode wakeup timer: offsets, fields, types
package swt_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_PORT_A_DATA = 8'h00;
  localparam logic [7:0] ADDR_KEYPAD_STATUS_CTRL = 8'h04;
  localparam logic [7:0] ADDR_KEYPAD_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_SYSTEM_CONFIG_TWO = 8'h0C;
  localparam logic [7:0] ADDR_SYSTEM_CONFIG_ONE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // Field positions
  localparam int PORTA_LATCH_BIT = 6;
  localparam int KSC_FLAG_BIT = 3;
  localparam int KSC_ACK_BIT = 2;
  localparam int KSC_MASK_BIT = 1;
  localparam int KIE_WAKE_BIT = 6;
  localparam int CFG2_OSC_BIT = 1;
  localparam int CFG1_PERIOD_BIT = 7;
  localparam int IRQ_PULSE_BIT = 0;
  localparam int IRQ_ENTRY_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // Wakeup periods in wakeup clock cycles
  localparam int PERIOD_SHORT = 512;
  localparam int PERIOD_LONG = 16384;
  localparam int CNT_WIDTH = 14;
  // Reset values
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 2'h0;
  localparam logic [CNT_WIDTH-1:0] CNT_RESET = 14'h0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic periodShort;
    logic oscRunInStop;
    logic wakeupIrqEnable;
    logic keypadIrqMask;
  } swt_cfg_t;

  localparam swt_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_COUNT = 1'b1
  } swt_state_t;
endpackage

/* File: swt_wakeup_timer.sv */
// Stop-mode wakeup timer with APB register access
// What this block does
// - Entering stop mode starts the generator automatically
// - Counter idle in run mode, active in stop
// - Wait mode keeps the timer inactive
// - Counter restarts from zero at stop entry
// - Oscillator bit clear: count RC oscillator ticks
// - Oscillator bit set: count doubled bus clock
// - Overflow count produces a wakeup request pulse
// - Period select one short, zero long
// - Short period 512, long 16384 cycles
// - Pulse sets latch only when enabled
// - Latch drives the shared keypad interrupt
// - Latch reads as port A bit six and keypad status bit three
// - Acknowledge write or reset clears latch
// - Latch readback ignores the enable bit
// - Acknowledge bit write-only, always reads zero
//
// Design decisions made here: the register addresses and the APB register port.
module swt_wakeup_timer #(
  parameter int LongPeriod = swt_pkg::PERIOD_LONG
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stopMode,
  input wire logic waitMode,
  input wire logic rcOscTick,
  input wire logic busClkX2Tick,
  output logic wakeupRequestPulse,
  output logic keypadIrqReq,
  output logic irq
);
  localparam logic [swt_pkg::CNT_WIDTH-1:0] SHORT_LAST =
    swt_pkg::CNT_WIDTH'(swt_pkg::PERIOD_SHORT - 1);
  localparam logic [swt_pkg::CNT_WIDTH-1:0] LONG_LAST =
    swt_pkg::CNT_WIDTH'(LongPeriod - 1);

  swt_pkg::swt_cfg_t cfg_r, cfg_nxt;
  swt_pkg::swt_state_t state_r, state_nxt;
  logic [swt_pkg::CNT_WIDTH-1:0] cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;
  logic latch_r, latch_nxt;
  logic keyIrq_r, keyIrq_nxt;
  logic [swt_pkg::IRQ_WIDTH-1:0] irqStat_r, irqStat_nxt;
  logic [swt_pkg::IRQ_WIDTH-1:0] irqMask_r, irqMask_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic tick;
  logic lastHit;
  logic stopActive;
  logic accessDone;
  logic ackWrite;
  logic entryEvent;

  // Address decode for the error answer; read mux and write strobes decode on their own
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == swt_pkg::ADDR_PORT_A_DATA) ||
      (a == swt_pkg::ADDR_KEYPAD_STATUS_CTRL) ||
      (a == swt_pkg::ADDR_KEYPAD_IRQ_ENABLE) ||
      (a == swt_pkg::ADDR_SYSTEM_CONFIG_TWO) ||
      (a == swt_pkg::ADDR_SYSTEM_CONFIG_ONE) ||
      (a == swt_pkg::ADDR_IRQ_STATUS) ||
      (a == swt_pkg::ADDR_IRQ_MASK);
  endfunction

  function automatic logic wrHit(input logic done, input logic wr,
                                 input logic [7:0] a, input logic [7:0] t);
    wrHit = done && wr && (a == t);
  endfunction

  assign accessDone = psel && penable && pready_r;
  assign ackWrite = wrHit(accessDone, pwrite, paddr,
    swt_pkg::ADDR_KEYPAD_STATUS_CTRL) && pwdata[swt_pkg::KSC_ACK_BIT];
  // Wait mode wins over a stop request
  assign stopActive = stopMode && !waitMode;
  assign tick = cfg_r.oscRunInStop ? busClkX2Tick : rcOscTick;
  assign lastHit = cnt_r == (cfg_r.periodShort ? SHORT_LAST
                                                : LONG_LAST);
  assign entryEvent = (state_r == swt_pkg::ST_IDLE) && stopActive;

  // Timer group
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    case (state_r)
      swt_pkg::ST_IDLE: begin
        cnt_nxt = swt_pkg::CNT_RESET;
        if (stopActive) begin
          state_nxt = swt_pkg::ST_COUNT;
        end
      end
      swt_pkg::ST_COUNT: begin
        if (!stopActive) begin
          // Gate off at once; a half period is not carried over
          state_nxt = swt_pkg::ST_IDLE;
          cnt_nxt = swt_pkg::CNT_RESET;
        end else if (tick) begin
          if (lastHit) begin
            cnt_nxt = swt_pkg::CNT_RESET;
            pulse_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      default: begin
        state_nxt = swt_pkg::ST_IDLE;
        cnt_nxt = swt_pkg::CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= swt_pkg::ST_IDLE;
      cnt_r <= swt_pkg::CNT_RESET;
      pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // Register and latch group
  always_comb begin
    cfg_nxt = cfg_r;
    irqMask_nxt = irqMask_r;
    // Set wins over a same-cycle acknowledge
    latch_nxt = (latch_r && !ackWrite) ||
      (pulse_r && cfg_r.wakeupIrqEnable);
    keyIrq_nxt = latch_r && !cfg_r.keypadIrqMask;
    irqStat_nxt = irqStat_r;
    if (wrHit(accessDone, pwrite, paddr, swt_pkg::ADDR_IRQ_STATUS)) begin
      irqStat_nxt = irqStat_r & ~pwdata[swt_pkg::IRQ_WIDTH-1:0];
    end
    if (pulse_r) begin
      irqStat_nxt[swt_pkg::IRQ_PULSE_BIT] = 1'b1;
    end
    if (entryEvent) begin
      irqStat_nxt[swt_pkg::IRQ_ENTRY_BIT] = 1'b1;
    end
    irq_nxt = |(irqStat_r & irqMask_r);
    if (wrHit(accessDone, pwrite, paddr,
              swt_pkg::ADDR_KEYPAD_STATUS_CTRL)) begin
      cfg_nxt.keypadIrqMask = pwdata[swt_pkg::KSC_MASK_BIT];
    end
    if (wrHit(accessDone, pwrite, paddr,
              swt_pkg::ADDR_KEYPAD_IRQ_ENABLE)) begin
      cfg_nxt.wakeupIrqEnable = pwdata[swt_pkg::KIE_WAKE_BIT];
    end
    if (wrHit(accessDone, pwrite, paddr,
              swt_pkg::ADDR_SYSTEM_CONFIG_TWO)) begin
      cfg_nxt.oscRunInStop = pwdata[swt_pkg::CFG2_OSC_BIT];
    end
    if (wrHit(accessDone, pwrite, paddr,
              swt_pkg::ADDR_SYSTEM_CONFIG_ONE)) begin
      cfg_nxt.periodShort = pwdata[swt_pkg::CFG1_PERIOD_BIT];
    end
    if (wrHit(accessDone, pwrite, paddr, swt_pkg::ADDR_IRQ_MASK)) begin
      irqMask_nxt = pwdata[swt_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Bus answer group: one wait state, then pready for one cycle
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = swt_pkg::DATA_ZERO;
    if (psel && penable && !pready_r) begin
      pslverr_nxt = !isMapped(paddr);
      if (!pwrite) begin
        case (paddr)
          swt_pkg::ADDR_PORT_A_DATA: begin
            // Only the latch lives here; no direction or pullup
            prdata_nxt[swt_pkg::PORTA_LATCH_BIT] = latch_r;
          end
          swt_pkg::ADDR_KEYPAD_STATUS_CTRL: begin
            prdata_nxt[swt_pkg::KSC_FLAG_BIT] = latch_r;
            prdata_nxt[swt_pkg::KSC_ACK_BIT] = 1'b0;
            prdata_nxt[swt_pkg::KSC_MASK_BIT] = cfg_r.keypadIrqMask;
          end
          swt_pkg::ADDR_KEYPAD_IRQ_ENABLE: begin
            prdata_nxt[swt_pkg::KIE_WAKE_BIT] = cfg_r.wakeupIrqEnable;
          end
          swt_pkg::ADDR_SYSTEM_CONFIG_TWO: begin
            prdata_nxt[swt_pkg::CFG2_OSC_BIT] = cfg_r.oscRunInStop;
          end
          swt_pkg::ADDR_SYSTEM_CONFIG_ONE: begin
            prdata_nxt[swt_pkg::CFG1_PERIOD_BIT] = cfg_r.periodShort;
          end
          swt_pkg::ADDR_IRQ_STATUS: begin
            prdata_nxt[swt_pkg::IRQ_WIDTH-1:0] = irqStat_r;
          end
          swt_pkg::ADDR_IRQ_MASK: begin
            prdata_nxt[swt_pkg::IRQ_WIDTH-1:0] = irqMask_r;
          end
          default: begin
            prdata_nxt = swt_pkg::DATA_ZERO;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r <= swt_pkg::CFG_RESET;
      latch_r <= 1'b0;
      keyIrq_r <= 1'b0;
      irqStat_r <= swt_pkg::IRQ_RESET;
      irqMask_r <= swt_pkg::IRQ_RESET;
      irq_r <= 1'b0;
      prdata_r <= swt_pkg::DATA_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      latch_r <= latch_nxt;
      keyIrq_r <= keyIrq_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wakeupRequestPulse = pulse_r;
  assign keypadIrqReq = keyIrq_r;
  assign irq = irq_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  run_idle_a: assert property (!stopActive |=> cnt_r == '0)
    else $error("counter not idle outside stop");
  wait_quiet_a: assert property (waitMode |=> ##1 !pulse_r)
    else $error("wakeup pulse during wait mode");
  entry_zero_a: assert property (entryEvent |=> cnt_r == '0 &&
    state_r == swt_pkg::ST_COUNT)
    else $error("stop entry did not start counter at zero");
  src_count_a: assert property (
    state_r == swt_pkg::ST_COUNT && stopActive && !lastHit && tick
    |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter missed selected clock tick");
  overflow_a: assert property (
    pulse_r |-> $past(lastHit) && $past(tick))
    else $error("pulse without overflow count");
  latch_set_a: assert property (pulse_r && cfg_r.wakeupIrqEnable
    |=> latch_r)
    else $error("enabled pulse did not set latch");
  latch_gate_a: assert property (!latch_r && !(pulse_r &&
    cfg_r.wakeupIrqEnable) |=> !latch_r)
    else $error("latch set without enabled pulse");
  ack_clear_a: assert property (latch_r && ackWrite && !pulse_r
    |=> !latch_r)
    else $error("acknowledge did not clear latch");
  key_irq_a: assert property (latch_r && !cfg_r.keypadIrqMask
    |=> keypadIrqReq)
    else $error("latched request not on keypad interrupt");
  ack_read_a: assert property (pready && !pwrite && psel &&
    paddr == swt_pkg::ADDR_KEYPAD_STATUS_CTRL
    |-> !prdata[swt_pkg::KSC_ACK_BIT])
    else $error("acknowledge bit read as one");
  porta_read_a: assert property (pready && !pwrite && psel &&
    paddr == swt_pkg::ADDR_PORT_A_DATA
    |-> prdata[swt_pkg::PORTA_LATCH_BIT] == $past(latch_r))
    else $error("port A bit six not the latch");
  exit_hold_a: assert property (
    state_r == swt_pkg::ST_COUNT && !stopActive && latch_r && !ackWrite
    |=> latch_r && state_r == swt_pkg::ST_IDLE)
    else $error("stop exit lost latch or kept counting");
  // Status and bus answer checks
  stat_set_a: assert property (pulse_r |=> irqStat_r[swt_pkg::IRQ_PULSE_BIT])
    else $error("request pulse did not set status");
  irq_level_a: assert property (|(irqStat_r & irqMask_r) |=> irq)
    else $error("unmasked status without interrupt");
  bad_addr_a: assert property (pready && psel && penable &&
    !isMapped(paddr) |-> pslverr)
    else $error("unmapped access without error");

  pulse_c: cover property (pulse_r && cfg_r.wakeupIrqEnable);
  short_c: cover property (pulse_r && cfg_r.periodShort);
  ack_c: cover property (latch_r && ackWrite);
  exit_c: cover property (latch_r ##1 !stopActive);
  entry_c: cover property (entryEvent);
endmodule // swt_wakeup_timer

/* File: swt_far_model.sv */
// Far-side model: wakeup clock sources and keypad request consumer
module swt_far_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic keypadIrqReq,
  output logic rcOscTick,
  output logic busClkX2Tick,
  output int wakeCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rcDiv_r;

  // Sources run freely, so an idle timer must ignore them itself
  always @(posedge sys_clk) begin
    rcDiv_r <= rst_n ? rcDiv_r + 2'h1 : 2'h0;
    rcOscTick <= rst_n && (rcDiv_r == 2'h3);
    busClkX2Tick <= rst_n;
  end

  // Core side sees wakeups only through the shared keypad request
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wakeCount <= 0;
    end else if (keypadIrqReq === 1'b1) begin
      wakeCount <= wakeCount + 1;
    end
  end
endmodule // swt_far_model

/* File: tb.sv */
// Testbench for the stop-mode wakeup timer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened long period keeps the run brief
  localparam int LongSim = 64;
  logic sys_clk, rst_n, psel, penable, pwrite, stopMode, waitMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, rcOscTick, busClkX2Tick;
  logic wakeupRequestPulse, keypadIrqReq, irq;
  int fails = 0;
  int checkCount = 0;
  int cycles = 0;
  int wakeCount;

  swt_wakeup_timer #(.LongPeriod(LongSim)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stopMode(stopMode), .waitMode(waitMode),
    .rcOscTick(rcOscTick), .busClkX2Tick(busClkX2Tick),
    .wakeupRequestPulse(wakeupRequestPulse),
    .keypadIrqReq(keypadIrqReq), .irq(irq));
  swt_far_model far (.sys_clk(sys_clk), .rst_n(rst_n),
    .keypadIrqReq(keypadIrqReq), .rcOscTick(rcOscTick),
    .busClkX2Tick(busClkX2Tick), .wakeCount(wakeCount));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the few thousand cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checkCount++;
    if (got !== want) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask

  // One idle edge first, so psel never toggles twice in one step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, want);
  endtask

  task automatic run(input int cyc, output int p);
    p = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      if (wakeupRequestPulse === 1'b1) p++;
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0);
    apb(1'b0, 8'h3C, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_idle();
    int p;
    wr(swt_pkg::ADDR_SYSTEM_CONFIG_TWO, 32'h2);
    wr(swt_pkg::ADDR_SYSTEM_CONFIG_ONE, 32'h80);
    run(600, p);
    check(32'(p), 32'h0);
    stopMode <= 1'b1;
    waitMode <= 1'b1;
    run(600, p);
    check(32'(p), 32'h0);
    stopMode <= 1'b0;
    waitMode <= 1'b0;
    $display("test idle done");
  endtask

  task automatic t_period(input logic src, input logic shrt);
    int n, want;
    want = (shrt ? swt_pkg::PERIOD_SHORT : LongSim) * (src ? 1 : 4);
    wr(swt_pkg::ADDR_SYSTEM_CONFIG_TWO, {30'h0, src, 1'h0});
    wr(swt_pkg::ADDR_SYSTEM_CONFIG_ONE, {24'h0, shrt, 7'h0});
    stopMode <= 1'b1;
    run(want / 2, n);
    // A short exit must restart the count, not resume it
    stopMode <= 1'b0;
    @(posedge sys_clk);
    stopMode <= 1'b1;
    n = 0;
    while (wakeupRequestPulse !== 1'b1 && n < 9000) begin
      @(posedge sys_clk);
      n++;
    end
    // Entry edge and pulse register add two; RC phase can land up to three cycles early
    if (src) check(32'(n), 32'(want + 2));
    else check(32'(n >= want - 1 && n <= want + 2), 32'h1);
    stopMode <= 1'b0;
    rdc(swt_pkg::ADDR_PORT_A_DATA, 32'h0);
    $display("test period done");
  endtask

  task automatic t_latch();
    int p;
    wr(swt_pkg::ADDR_SYSTEM_CONFIG_TWO, 32'h2);
    wr(swt_pkg::ADDR_SYSTEM_CONFIG_ONE, 32'h0);
    wr(swt_pkg::ADDR_KEYPAD_IRQ_ENABLE, 32'h40);
    // Earlier scenarios left status bits set
    wr(swt_pkg::ADDR_IRQ_STATUS, 32'h3);
    wr(swt_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(swt_pkg::ADDR_KEYPAD_STATUS_CTRL, 32'h0);
    check({31'h0, irq}, 32'h0);
    stopMode <= 1'b1;
    run(LongSim + 13, p);
    check(32'(p), 32'h1);
    check({31'h0, keypadIrqReq}, 32'h1);
    check({31'h0, irq}, 32'h1);
    stopMode <= 1'b0;
    run(200, p);
    check(32'(p), 32'h0);
    check(32'(wakeCount > 0), 32'h1);
    rdc(swt_pkg::ADDR_PORT_A_DATA, 32'h40);
    rdc(swt_pkg::ADDR_KEYPAD_STATUS_CTRL, 32'h8);
    wr(swt_pkg::ADDR_KEYPAD_IRQ_ENABLE, 32'h0);
    rdc(swt_pkg::ADDR_PORT_A_DATA, 32'h40);
    wr(swt_pkg::ADDR_KEYPAD_STATUS_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk);
    check({31'h0, keypadIrqReq}, 32'h0);
    wr(swt_pkg::ADDR_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    rdc(swt_pkg::ADDR_IRQ_STATUS, 32'h0);
    wr(swt_pkg::ADDR_KEYPAD_STATUS_CTRL, 32'h4);
    rdc(swt_pkg::ADDR_PORT_A_DATA, 32'h0);
    rdc(swt_pkg::ADDR_KEYPAD_STATUS_CTRL, 32'h0);
    $display("test latch done");
  endtask

  task automatic t_rst_latch();
    int p;
    wr(swt_pkg::ADDR_KEYPAD_IRQ_ENABLE, 32'h40);
    stopMode <= 1'b1;
    run(LongSim + 13, p);
    stopMode <= 1'b0;
    rdc(swt_pkg::ADDR_PORT_A_DATA, 32'h40);
    // Mid-run reset must drop a pending request
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    check({31'h0, keypadIrqReq}, 32'h0);
    rdc(swt_pkg::ADDR_PORT_A_DATA, 32'h0);
    rdc(swt_pkg::ADDR_KEYPAD_IRQ_ENABLE, 32'h0);
    $display("test reset latch done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stopMode = 1'b0;
    waitMode = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_idle();
    for (int i = 0; i < 4; i++) t_period(i[0], i[1]);
    t_latch();
    t_rst_latch();
    finish_test();
  end
endmodule // tb
